// >>> core/pte_ctrl_bank.sv
`timescale 1ns/1ps
module pte_ctrl_bank
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [pte_pkg::AW-1:0] paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [pte_pkg::DW-1:0] pwdata,
    output logic      [pte_pkg::DW-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [pte_pkg::NCH-1:0] loop_zero,
    input  wire logic [pte_pkg::NCH-1:0] square_mode,
    input  wire logic [pte_pkg::NCH-1:0] chan_on,
    output logic      [pte_pkg::NCH-1:0] chan_en_set,
    output logic                       irq
);
    import pte_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------

    // One-hot register select; zero means unmapped
    // Decoded once here so the read mux, the write strobes and the
    // error answer can never disagree about which register is hit
    function automatic logic [NSEL-1:0] reg_sel(
        input logic [AW-1:0] a
    );
        logic [NSEL-1:0] s;
        s = '0;
        case (a)
            OFS_IRQ_EN: begin
                s[SEL_IRQ_EN] = 1'b1;
            end
            OFS_FLAGS: begin
                s[SEL_FLAGS] = 1'b1;
            end
            OFS_SET_EN: begin
                s[SEL_SET_EN] = 1'b1;
            end
            default: begin
                s = '0;
            end
        endcase
        return s;
    endfunction

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    // Enables and flags are held as four bits only
    logic [NSEL-1:0] sel;            // Decoded select
    logic            setup;          // APB setup cycle, read
    logic            acc;            // APB access cycle
    logic            wr;             // Write completes this edge
    logic            unmapped;       // No register at paddr
    logic [NCH-1:0]  stop_irq_enable; // Interrupt enables
    logic [NCH-1:0]  stopped_flags;  // Sticky stop flags
    logic [NCH-1:0]  stop_ev;        // Qualified stop events
    logic [NCH-1:0]  flag_clr;       // Write-one-to-clear strobes
    logic [NCH-1:0]  next_set;       // Next enable set pulse
    logic [DW-1:0]   next_rdata;     // Read mux output

    // ------------------------------------------------------------
    // APB slave: zero wait states
    // ------------------------------------------------------------

    // Every access ends in its first access cycle
    // No wait states: every register answers from flops or a mux,
    // so there is nothing that could need more time
    assign pready = 1'b1;

    // Phase decode of the bus
    always_comb begin
        sel      = reg_sel(paddr);
        setup    = psel & ~penable & ~pwrite;
        acc      = psel & penable;
        wr       = acc & pwrite;
        unmapped = (sel == '0);
    end

    // Unmapped addresses answer with an error, no side effect
    // Reads of an unmapped address return zero as well
    always_comb begin
        pslverr = acc & unmapped;
    end

    // Read mux; write-only port and reserved bits read zero
    always_comb begin
        next_rdata = '0;
        if (sel[SEL_IRQ_EN]) begin
            next_rdata[CH_MSB:CH_LSB] = stop_irq_enable;
        end else if (sel[SEL_FLAGS]) begin
            next_rdata[CH_MSB:CH_LSB] = stopped_flags;
        end else begin
            next_rdata = '0;
        end
    end

    // Read data is captured in the setup cycle so it comes from
    // a flip-flop; a flag set during the access shows next read
    // Limitation: a master that reads without a setup cycle gets
    // stale data, which plain APB never does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= RDATA_RST;
        end else if (setup) begin
            prdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Interrupt enable register
    // ------------------------------------------------------------

    // Plain read-write bits; upper bits of the write are dropped
    // Reserved bits are not stored at all, so they read back zero
    // without any masking in the read mux
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_irq_enable <= IRQ_EN_RST;
        end else if (wr && sel[SEL_IRQ_EN]) begin
            stop_irq_enable <= pwdata[CH_MSB:CH_LSB];
        end
    end

    // ------------------------------------------------------------
    // Stopped flags
    // ------------------------------------------------------------

    // Only a loop count running out in pulse train mode on an
    // enabled channel is a stop; a disable simply halts output
    // A channel switched off in the cycle its count runs out is
    // treated as a disable, so no flag is raised
    always_comb begin
        stop_ev = loop_zero & ~square_mode & chan_on;
    end

    // Clear strobes from a write of ones to the flag register
    always_comb begin
        flag_clr = '0;
        if (wr && sel[SEL_FLAGS]) begin
            flag_clr = pwdata[CH_MSB:CH_LSB];
        end
    end

    // One sticky cell per channel
    // Each cell lets a set win over a clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_flag
            pte_w1c_bit u_flag (
                .pclk    (pclk),
                .presetn (presetn),
                .set_ev  (stop_ev[gi]),
                .clr_ev  (flag_clr[gi]),
                .flag    (stopped_flags[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Enable set port
    // ------------------------------------------------------------

    // Ones in the written value become a one-cycle set pulse that
    // the channel enable register ORs in; zeros touch nothing
    // The enable register sits outside this bank; it must OR the
    // pulse in on the edge that follows, with no read back
    always_comb begin
        next_set = '0;
        if (wr && sel[SEL_SET_EN]) begin
            next_set = pwdata[CH_MSB:CH_LSB];
        end
    end

    // Registered pulse, one cycle after the write completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_en_set <= '0;
        end else begin
            chan_en_set <= next_set;
        end
    end

    // ------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------

    // Level output, held while any enabled flag stays set;
    // registered to keep glitches off the interrupt line
    // Costs one cycle of latency, which no handler can notice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stopped_flags & stop_irq_enable);
        end
    end

    // ------------------------------------------------------------
    // Helper state for checks
    // ------------------------------------------------------------
    // Only the checks read these; synthesis trims them away
    logic [NCH-1:0] ev_q;            // Stop events, last cycle
    logic [NCH-1:0] on_q;            // Channel on, last cycle
    logic [NCH-1:0] sq_q;            // Square mode, last cycle
    logic [NCH-1:0] clr_q;           // Clear strobes, last cycle
    logic [NCH-1:0] flags_q;         // Flags, last cycle
    logic [NCH-1:0] wd_q;            // Write data, last cycle
    logic [NCH-1:0] new_flags;       // Flags that just rose

    // Snapshot of last cycle for rising-flag checks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_q    <= '0;
            on_q    <= '0;
            sq_q    <= '0;
            clr_q   <= '0;
            flags_q <= '0;
            wd_q    <= '0;
        end else begin
            ev_q    <= stop_ev;
            on_q    <= chan_on;
            sq_q    <= square_mode;
            clr_q   <= flag_clr;
            flags_q <= stopped_flags;
            wd_q    <= pwdata[CH_MSB:CH_LSB];
        end
    end

    assign new_flags = stopped_flags & ~flags_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    // Each check watches what the bank drives, against the bus and
    // the channel inputs one cycle back; all are cut by reset
    chk_stop_sets_flag: assert property (
        (stop_ev != '0) |=> ((stopped_flags & ev_q) == ev_q))
        else $error("stop event did not set its flag");

    chk_square_no_set: assert property (
        (new_flags & sq_q) == '0)
        else $error("flag rose without a pulse train stop");

    chk_w1c_clears: assert property (
        (wr && sel[SEL_FLAGS] && stop_ev == '0)
        |=> ((stopped_flags & wd_q) == '0))
        else $error("write one did not clear flag");

    chk_flags_sticky: assert property (
        ((flags_q & ~stopped_flags & ~clr_q) == '0))
        else $error("flag fell without a clear");

    chk_flags_upper_zero: assert property (
        (acc && !pwrite && sel[SEL_FLAGS])
        |-> (prdata[DW-1:CH_MSB+1] == '0
             && prdata[CH_MSB:CH_LSB] == flags_q))
        else $error("flag read data wrong");

    chk_en_read: assert property (
        (acc && !pwrite && sel[SEL_IRQ_EN])
        |-> (prdata[DW-1:CH_MSB+1] == '0
             && prdata[CH_MSB:CH_LSB] == stop_irq_enable))
        else $error("interrupt enable read data wrong");

    chk_irq_masked: assert property (
        ((stopped_flags & stop_irq_enable) == '0)
        |=> !irq)
        else $error("interrupt without enabled flag");

    chk_en_written: assert property (
        (wr && sel[SEL_IRQ_EN])
        |=> (stop_irq_enable == wd_q) ##1 (stop_irq_enable == $past(wd_q)))
        else $error("interrupt enable write lost");

    chk_set_pulse: assert property (
        (wr && sel[SEL_SET_EN])
        |=> (chan_en_set == wd_q) ##1 (chan_en_set == '0
            || $past(wr)))
        else $error("enable set pulse wrong");

    chk_set_idle: assert property (
        !(wr && sel[SEL_SET_EN]) |=> (chan_en_set == '0))
        else $error("enable set pulse without write");

    chk_set_read_zero: assert property (
        (acc && !pwrite && sel[SEL_SET_EN]) |-> (prdata == '0))
        else $error("enable set port read back data");

    chk_disable_no_set: assert property (
        (new_flags & ~on_q) == '0)
        else $error("flag rose on a disabled channel");

    chk_irq_raise: assert property (
        ((stopped_flags & stop_irq_enable) != '0
         && !wr)
        |=> irq ##1 (irq || $past(wr)))
        else $error("interrupt not raised");

    chk_err_unmapped: assert property (
        (acc && unmapped) |-> pslverr ##1 !pslverr || acc)
        else $error("unmapped access not refused");

    chk_err_mapped: assert property (
        (acc && !unmapped) |-> !pslverr)
        else $error("mapped access refused");

    // ------------------------------------------------------------
    // Coverage of main scenarios
    // ------------------------------------------------------------
    // Each should be reached by the bench; a miss means a lost scenario
    cov_irq_rise: cover property ($rose(irq));

    cov_clear_race: cover property (
        (wr && sel[SEL_FLAGS] && (flag_clr & stop_ev) != '0));

    cov_set_write: cover property (
        (wr && sel[SEL_SET_EN]) ##1 (chan_en_set != '0));

    cov_square_stop: cover property (
        (loop_zero & square_mode) != '0);

    cov_b2b_set: cover property (
        (wr && sel[SEL_SET_EN]) ##2 (wr && sel[SEL_SET_EN]));

endmodule

// >>> core/pte_pkg.sv
package pte_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NCH = 4;                   // Channels in the engine
    localparam int AW  = 12;                  // APB address width
    localparam int DW  = 32;                  // APB data width

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [AW-1:0] OFS_IRQ_EN  = 12'h000; // stop_irq_enable
    localparam logic [AW-1:0] OFS_FLAGS   = 12'h008; // stopped_flags
    localparam logic [AW-1:0] OFS_SET_EN  = 12'h010; // enable_set_port

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int CH_LSB = 0;                // Channel bits start here
    localparam int CH_MSB = 3;                // Bits above read as zero
    localparam logic [NCH-1:0] IRQ_EN_RST = 4'h0;
    localparam logic [NCH-1:0] FLAGS_RST  = 4'h0;
    localparam logic [DW-1:0]  RDATA_RST  = 32'h0000_0000;

    // Index of each register in the one-hot select
    localparam int SEL_IRQ_EN = 0;
    localparam int SEL_FLAGS  = 1;
    localparam int SEL_SET_EN = 2;
    localparam int NSEL       = 3;

endpackage

// >>> core/pte_w1c_bit.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Sticky flag cell, set by hardware, cleared by writing one
// ------------------------------------------------------------
module pte_w1c_bit
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic set_ev,    // Hardware event, one cycle
    input  wire logic clr_ev,    // Software clear, one cycle
    output logic      flag       // Sticky flag
);
    import pte_pkg::*;

    logic next_flag;             // Value for the next edge

    // Set wins over clear so an event in the clear cycle survives
    always_comb begin
        next_flag = set_ev | (flag & ~clr_ev);
    end

    // Flag register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

    // Event in the clearing cycle must still show next cycle
    chk_set_beats_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (set_ev && clr_ev) |=> flag)
        else $error("flag lost an event during clear");

endmodule

// >>> tb/pte_ctrl_bank_tb.sv
`timescale 1ns/1ps
module pte_ctrl_bank_tb;
    import pte_pkg::*;

    // ------------------------------------------------------------
    // Bench signals
    // ------------------------------------------------------------
    logic            pclk;
    logic            presetn;
    logic [AW-1:0]   paddr;
    logic            psel;
    logic            penable;
    logic            pwrite;
    logic [DW-1:0]   pwdata;
    logic [DW-1:0]   prdata;
    logic            pready;
    logic            pslverr;
    logic [NCH-1:0]  loop_zero;
    logic [NCH-1:0]  square_mode;
    logic [NCH-1:0]  chan_on;
    logic [NCH-1:0]  chan_en_set;
    logic            irq;
    int              err_count;   // Mismatches seen
    int              compares;    // Comparisons made
    logic [DW-1:0]   rd;          // Data of the last transfer
    logic            slverr;      // Error answer of the last transfer
    // Rows: irq enables, square mode, channel on, loop zero, expected flags
    logic [19:0]     rows [6] = '{20'hf0f11, 20'h00f22, 20'hf4fc8, 20'hf0780, 20'h50fff, 20'h8fff0};

    pte_ctrl_bank pte_ctrl_bank_inst (
        .pclk        (pclk),
        .presetn     (presetn),
        .paddr       (paddr),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .loop_zero   (loop_zero),
        .square_mode (square_mode),
        .chan_on     (chan_on),
        .chan_en_set (chan_en_set),
        .irq         (irq)
    );

    // Free running 10 MHz clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Helper tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Setup then access; the request stays up so a next setup may follow at once
    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 16) begin
                err_count++;
                tally_and_finish();
            end
            @(posedge pclk);
        end
        rd     = prdata;
        slverr = pslverr;
    endtask

    // Release the bus for one cycle
    task automatic idle();
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        idle();
        chk(nm, rd, exp);
    endtask

    // One cycle stop strobe, then wait until the registered irq has settled
    task automatic stop_ev(input logic [3:0] lz);
        loop_zero <= lz;
        @(posedge pclk);
        loop_zero <= 4'h0;
        repeat (2) @(posedge pclk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = '0;
        pwdata      = '0;
        loop_zero   = '0;
        square_mode = '0;
        chan_on     = '0;
        err_count   = 0;
        compares    = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("irq_rst", {31'h0, irq}, 32'h0);
        chk("set_rst", {28'h0, chan_en_set}, 32'h0);
        rd_chk(OFS_IRQ_EN, 32'h0, "en_rst");
        rd_chk(OFS_FLAGS, 32'h0, "flags_rst");
        $display("test reset done");
        // Ordinary cases: mode, enable and mask combinations
        foreach (rows[i]) begin
            apb(1'b1, OFS_IRQ_EN, {28'h0, rows[i][19:16]});
            square_mode <= rows[i][15:12];
            chan_on     <= rows[i][11:8];
            idle();
            stop_ev(rows[i][7:4]);
            chk("irq_row", {31'h0, irq}, {31'h0, |(rows[i][3:0] & rows[i][19:16])});
            rd_chk(OFS_FLAGS, {28'h0, rows[i][3:0]}, "flags_row");
            rd_chk(OFS_IRQ_EN, {28'h0, rows[i][19:16]}, "en_row");
            apb(1'b1, OFS_FLAGS, 32'hffff_ffff);
            idle();
            rd_chk(OFS_FLAGS, 32'h0, "flags_clr");
            chk("irq_clr", {31'h0, irq}, 32'h0);
        end
        square_mode <= 4'h0;
        chan_on     <= 4'hf;
        $display("test rows done");
        // Reserved bits ignored, masked flag then unmasked
        apb(1'b1, OFS_IRQ_EN, 32'hffff_fffa);
        idle();
        rd_chk(OFS_IRQ_EN, 32'h0000_000a, "en_rsvd");
        stop_ev(4'h1);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        apb(1'b1, OFS_IRQ_EN, 32'h0000_0001);
        idle();
        @(posedge pclk);
        chk("irq_unmask", {31'h0, irq}, 32'h1);
        // Event only in the clearing access cycle keeps the flag
        fork
            apb(1'b1, OFS_FLAGS, 32'h0000_0001);
            begin
                @(posedge pclk);
                loop_zero <= 4'h1;
                @(posedge pclk);
                loop_zero <= 4'h0;
            end
        join
        idle();
        rd_chk(OFS_FLAGS, 32'h0000_0001, "flags_race");
        apb(1'b1, OFS_FLAGS, 32'h0000_0001);
        idle();
        rd_chk(OFS_FLAGS, 32'h0, "flags_clr2");
        $display("test mask and clear done");
        // Set port: pulse per written one, zero bits give nothing
        apb(1'b1, OFS_SET_EN, 32'hffff_fff5);
        idle();
        chk("set_a", {28'h0, chan_en_set}, 32'h5);
        idle();
        chk("set_end", {28'h0, chan_en_set}, 32'h0);
        apb(1'b1, OFS_SET_EN, 32'h0000_000a);
        idle();
        chk("set_b", {28'h0, chan_en_set}, 32'ha);
        apb(1'b1, OFS_SET_EN, 32'h0000_000a);
        apb(1'b1, OFS_SET_EN, 32'h0000_0000);
        idle();
        chk("set_zero", {28'h0, chan_en_set}, 32'h0);
        rd_chk(OFS_SET_EN, 32'h0, "set_read");
        $display("test set port done");
        // Unmapped address answers with an error and no data
        apb(1'b0, 12'h004, 32'h0);
        idle();
        chk("unmapped_err", {31'h0, slverr}, 32'h1);
        chk("unmapped_dat", rd, 32'h0);
        // Reset in mid run clears flags, enables and irq
        stop_ev(4'h1);
        chk("irq_pre", {31'h0, irq}, 32'h1);
        presetn <= 1'b0;
        @(posedge pclk);
        chk("irq_rst2", {31'h0, irq}, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(OFS_FLAGS, 32'h0, "flags_rst2");
        rd_chk(OFS_IRQ_EN, 32'h0, "en_rst2");
        $display("test late reset done");
        tally_and_finish();
    end

endmodule
